// File: inc/pvp_pkg.sv
// constants and types of the process value postprocessor
// assumes a 100 MHz system clock and a 32-bit apb register bus
package pvp_pkg;
	// ****************************************************************
	// clock and times
	// ****************************************************************
	localparam int CLK_MHZ     = 100;
	localparam int CYC_PER_MS  = CLK_MHZ * 1000;
	localparam int EVT_FLT_MS  = 30;
	localparam int SLOW_FLT_MS = 10;
	localparam int ZERO_CLR_MS = 1000;
	localparam int HIGH_FLT_CYC = 1;
	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HYST = 8'h04;
	localparam logic [7:0] OFS_SPA1 = 8'h08;
	localparam logic [7:0] OFS_SPB1 = 8'h0C;
	localparam logic [7:0] OFS_SPA2 = 8'h10;
	localparam logic [7:0] OFS_SPB2 = 8'h14;
	localparam logic [7:0] OFS_KEY  = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;
	localparam logic [7:0] OFS_PV   = 8'h20;
	// ****************************************************************
	// field positions and widths
	// ****************************************************************
	localparam int CTRL_ITYPE = 0;
	localparam int CTRL_AVG   = 2;
	localparam int CTRL_EVTF  = 4;
	localparam int CTRL_FAST  = 5;
	localparam int CTRL_COLOR = 6;
	localparam int CTRL_T1    = 8;
	localparam int CTRL_T2    = 10;
	localparam int CTRL_W     = 12;
	localparam int KEY_SET    = 0;
	localparam int KEY_CLR    = 1;
	localparam int HYST_W     = 14;
	// ****************************************************************
	// reset values and hysteresis limit
	// ****************************************************************
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [13:0] HYST_RST = 14'h0001;
	localparam logic [13:0] HYST_MAX = 14'h270F;
	localparam logic [31:0] SP_RST   = 32'h0000_0000;
	// ****************************************************************
	// modes
	// ****************************************************************
	typedef enum logic [1:0] {
		IT_ANALOG = 2'h0, IT_REMOTE = 2'h1, IT_PULSE = 2'h2, IT_RSV = 2'h3
	} pvp_itype_type;
	typedef enum logic [1:0] {
		CT_UPPER = 2'h0, CT_LOWER = 2'h1, CT_RANGE = 2'h2, CT_RSV = 2'h3
	} pvp_ctype_type;
	typedef enum logic [1:0] {
		CM_G2R = 2'h0, CM_GREEN = 2'h1, CM_RED = 2'h2, CM_R2G = 2'h3
	} pvp_color_type;
endpackage

// File: src/pvp_top.sv
// process value averaging, event input, hold, zero offset, compares
// assumes synchronous inputs, apb master and a nonvolatile store outside
// ****************************************************************
// top module
// ****************************************************************
// How it works
// - mean of 1, 2, 4 or 8 samples
// - update every 250 ms times averaging count
// - slow pulses update once per n pulses
// - shared input is event or pulse by type
// - event drives hold or zero by setting
// - event input debounced for 30 ms
// - slow pulse input filtered against chatter
// - hold captures value on rise, keeps it
// - hold for every input type but pulse
// - pulse type disables all zeroing
// - each zero request rezeroes on present value
// - zero request held one second cancels offset
// - key zero actions go to nonvolatile store
// - later event zero overrides key zero
// - upper limit with hysteresis below setpoint
// - lower limit with hysteresis above setpoint
// - outside range with inner hysteresis band
// - two independently typed compare outputs
// - hysteresis 1 to 9999 used everywhere
// - display colour from four modes
//
// The implementer's own choices: the placing of the registers and the APB slave port.
module pvp_top
	import pvp_pkg::*;
#(
	parameter int EVT_FLT_CYC  = EVT_FLT_MS * CYC_PER_MS,
	parameter int SLOW_FLT_CYC = SLOW_FLT_MS * CYC_PER_MS,
	parameter int ZERO_CLR_CYC = ZERO_CLR_MS * CYC_PER_MS
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] meas_data,
	input  wire logic        meas_strobe,
	input  wire logic        pulse_slow,
	input  wire logic        ext_in,
	input  wire logic        nv_zero_act,
	input  wire logic [31:0] nv_offset,
	output logic             nv_wr,
	output logic             nv_wr_zero_act,
	output logic      [31:0] nv_wr_offset,
	output logic      [31:0] pv_out,
	output logic             pv_upd,
	output logic             cmp1_out,
	output logic             cmp2_out,
	output logic             color_red
);
	import pvp_pkg::*;

	logic        [11:0] ctrl_reg;
	logic        [13:0] hyst_reg;
	logic signed [31:0] spa1_reg, spb1_reg, spa2_reg, spb2_reg;
	logic               key_set_reg, key_clr_reg;
	logic        [31:0] rd_next;
	logic               err_next;
	pvp_itype_type      itype;
	pvp_ctype_type      t1, t2;
	pvp_color_type      cmode;
	logic        [1:0]  avg_sel;
	logic               evt_zero, is_pulse, wr_en;

	assign itype    = pvp_itype_type'(ctrl_reg[CTRL_ITYPE +: 2]);
	assign avg_sel  = ctrl_reg[CTRL_AVG +: 2];
	assign evt_zero = ctrl_reg[CTRL_EVTF];
	assign cmode    = pvp_color_type'(ctrl_reg[CTRL_COLOR +: 2]);
	assign t1       = pvp_ctype_type'(ctrl_reg[CTRL_T1 +: 2]);
	assign t2       = pvp_ctype_type'(ctrl_reg[CTRL_T2 +: 2]);
	assign is_pulse = (itype == IT_PULSE);
	assign wr_en    = psel & penable & pready & pwrite;

	// ****************************************************************
	// apb slave
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= (psel & ~penable & ~pwrite) ? rd_next : 32'h0000_0000;
			pslverr <= psel & ~penable & err_next;
		end
	end

	logic        [27:0] zcnt_reg;
	logic               zero_act_reg, hold_reg, flt_reg;
	logic signed [31:0] raw_reg, off_reg, live_pv;

	always_comb begin
		rd_next  = 32'h0000_0000;
		err_next = 1'b0;
		unique case (paddr)
			OFS_CTRL: rd_next = {20'h0_0000, ctrl_reg};
			OFS_HYST: rd_next = {18'h0_0000, hyst_reg};
			OFS_SPA1: rd_next = spa1_reg;
			OFS_SPB1: rd_next = spb1_reg;
			OFS_SPA2: rd_next = spa2_reg;
			OFS_SPB2: rd_next = spb2_reg;
			OFS_KEY:  rd_next = 32'h0000_0000;
			OFS_STAT: rd_next = {26'h000_0000, flt_reg, hold_reg,
				zero_act_reg, color_red, cmp2_out, cmp1_out};
			OFS_PV:   rd_next = pv_out;
			default:  err_next = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= CTRL_RST;
			hyst_reg <= HYST_RST;
			spa1_reg <= SP_RST;
			spb1_reg <= SP_RST;
			spa2_reg <= SP_RST;
			spb2_reg <= SP_RST;
		end else if (wr_en) begin
			unique case (paddr)
				OFS_CTRL: ctrl_reg <= pwdata[CTRL_W-1:0];
				OFS_HYST: if (pwdata[13:0] != 14'h0000 &&
					pwdata[13:0] <= HYST_MAX &&
					pwdata[31:14] == 18'h0_0000) begin
					hyst_reg <= pwdata[13:0];
				end
				OFS_SPA1: spa1_reg <= pwdata;
				OFS_SPB1: spb1_reg <= pwdata;
				OFS_SPA2: spa2_reg <= pwdata;
				OFS_SPB2: spb2_reg <= pwdata;
				default:  ;
			endcase
		end
	end

	// key requests are ignored for pulse input
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			key_set_reg <= 1'b0;
			key_clr_reg <= 1'b0;
		end else begin
			key_set_reg <= wr_en && paddr == OFS_KEY &&
				pwdata[KEY_SET] && !is_pulse;
			key_clr_reg <= wr_en && paddr == OFS_KEY &&
				pwdata[KEY_CLR] && !is_pulse;
		end
	end

	// ****************************************************************
	// shared input filter
	// ****************************************************************
	logic [26:0] flt_cnt_reg, flt_len;
	logic        flt_d_reg, flt_rise;

	always_comb begin
		if (!is_pulse) begin
			flt_len = 27'(EVT_FLT_CYC);
		end else if (!ctrl_reg[CTRL_FAST]) begin
			flt_len = 27'(SLOW_FLT_CYC);
		end else begin
			flt_len = 27'(HIGH_FLT_CYC);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flt_reg     <= 1'b0;
			flt_cnt_reg <= 27'h000_0000;
		end else if (ext_in == flt_reg) begin
			flt_cnt_reg <= 27'h000_0000;
		end else if (flt_cnt_reg >= flt_len - 27'h000_0001) begin
			flt_reg     <= ext_in;
			flt_cnt_reg <= 27'h000_0000;
		end else begin
			flt_cnt_reg <= flt_cnt_reg + 27'h000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flt_d_reg <= 1'b0;
		end else begin
			flt_d_reg <= flt_reg;
		end
	end
	assign flt_rise = flt_reg & ~flt_d_reg;

	AST_FLT_WIDTH: assert property (@(posedge clk_sys) disable iff (!arst_n)
		flt_reg != $past(flt_reg) |-> $past(flt_cnt_reg) == $past(flt_len)
		- 27'h000_0001) else $error("filter passed a short level");

	// ****************************************************************
	// averaging
	// ****************************************************************
	logic signed [34:0] sum_reg, sum_nx;
	logic        [2:0]  acc_reg;
	logic               smp, upd_reg;

	// slow pulses: one sample per filtered pulse
	assign smp    = (is_pulse && pulse_slow) ? flt_rise : meas_strobe;
	assign sum_nx = sum_reg + 35'(signed'(meas_data));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sum_reg <= 35'h0_0000_0000;
			acc_reg <= 3'h0;
			raw_reg <= 32'h0000_0000;
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= 1'b0;
			if (smp) begin
				if (acc_reg >= 3'((4'h1 << avg_sel) - 4'h1)) begin
					raw_reg <= 32'(sum_nx >>> avg_sel);
					sum_reg <= 35'h0_0000_0000;
					acc_reg <= 3'h0;
					upd_reg <= 1'b1;
				end else begin
					sum_reg <= sum_nx;
					acc_reg <= acc_reg + 3'h1;
				end
			end
		end
	end

	AST_AVG_ONE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		smp && avg_sel == 2'h0 && acc_reg == 3'h0 |=>
		upd_reg && raw_reg == $past(meas_data))
		else $error("single sample not passed");
	AST_UPD_CAUSE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		upd_reg |-> $past(smp) && $past(acc_reg) ==
		3'((4'h1 << $past(avg_sel)) - 4'h1))
		else $error("update without full sample set");

	// ****************************************************************
	// hold and zero
	// ****************************************************************
	logic signed [31:0] held_reg;
	logic               zreq, zreq_d_reg, hreq, nv_ld_reg;

	assign hreq = flt_reg && !evt_zero && !is_pulse;
	assign zreq = flt_reg && evt_zero && !is_pulse;
	assign live_pv = zero_act_reg ? raw_reg - off_reg : raw_reg;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hold_reg <= 1'b0;
			held_reg <= 32'h0000_0000;
		end else begin
			hold_reg <= hreq;
			if (hreq && !hold_reg) begin
				held_reg <= live_pv;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			zreq_d_reg   <= 1'b0;
			zcnt_reg     <= 28'h000_0000;
			zero_act_reg <= 1'b0;
			off_reg      <= 32'h0000_0000;
			nv_ld_reg    <= 1'b0;
		end else begin
			zreq_d_reg <= zreq;
			nv_ld_reg  <= 1'b1;
			if (!zreq) begin
				zcnt_reg <= 28'h000_0000;
			end else if (zcnt_reg < 28'(ZERO_CLR_CYC)) begin
				zcnt_reg <= zcnt_reg + 28'h000_0001;
			end
			if (!nv_ld_reg) begin
				zero_act_reg <= nv_zero_act;
				off_reg      <= nv_offset;
			end else if (zreq && !zreq_d_reg) begin
				zero_act_reg <= 1'b1;
				off_reg      <= raw_reg;
			end else if (zreq && zcnt_reg == 28'(ZERO_CLR_CYC - 1)) begin
				zero_act_reg <= 1'b0;
				off_reg      <= 32'h0000_0000;
			end else if (key_set_reg) begin
				zero_act_reg <= 1'b1;
				off_reg      <= raw_reg;
			end else if (key_clr_reg) begin
				zero_act_reg <= 1'b0;
				off_reg      <= 32'h0000_0000;
			end
		end
	end

	// only key actions reach the store
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			nv_wr          <= 1'b0;
			nv_wr_zero_act <= 1'b0;
			nv_wr_offset   <= 32'h0000_0000;
		end else begin
			nv_wr <= nv_ld_reg && !(zreq && !zreq_d_reg) &&
				!(zreq && zcnt_reg == 28'(ZERO_CLR_CYC - 1)) &&
				(key_set_reg || key_clr_reg);
			if (key_set_reg || key_clr_reg) begin
				nv_wr_zero_act <= key_set_reg;
				nv_wr_offset   <= key_set_reg ? raw_reg : 32'h0000_0000;
			end
		end
	end

	AST_ZERO_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
		nv_ld_reg && zreq && !zreq_d_reg |=>
		zero_act_reg && off_reg == $past(raw_reg))
		else $error("zero request did not take offset");
	AST_ZERO_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n)
		nv_ld_reg && zreq && zreq_d_reg &&
		zcnt_reg == 28'(ZERO_CLR_CYC - 1) |=> !zero_act_reg)
		else $error("long zero request did not cancel");
	AST_PULSE_NOZERO: assert property (@(posedge clk_sys)
		disable iff (!arst_n)
		nv_ld_reg && is_pulse && $past(is_pulse) && $past(is_pulse, 2)
		|-> $stable(off_reg) && !nv_wr)
		else $error("zero changed in pulse mode");
	AST_NV_KEY: assert property (@(posedge clk_sys) disable iff (!arst_n)
		nv_wr |-> $past(key_set_reg || key_clr_reg) &&
		!$past(zreq && !zreq_d_reg))
		else $error("store written without key");

	// ****************************************************************
	// compare outputs and colour
	// ****************************************************************
	function automatic logic cmp_next(input pvp_ctype_type t,
		input logic cur, input logic signed [31:0] v,
		input logic signed [31:0] a, input logic signed [31:0] b,
		input logic [13:0] h);
		logic signed [31:0] hs;
		hs = {18'h0_0000, h};
		cmp_next = 1'b0;
		unique case (t)
			CT_UPPER: cmp_next = cur ? !(v <= a - hs) : (v >= a);
			CT_LOWER: cmp_next = cur ? !(v >= a + hs) : (v <= a);
			CT_RANGE: cmp_next = cur ? !(v <= a - hs && v >= b + hs)
				: (v >= a || v <= b);
			default:  cmp_next = 1'b0;
		endcase
	endfunction

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmp1_out <= 1'b0;
			cmp2_out <= 1'b0;
		end else if (upd_reg) begin
			cmp1_out <= cmp_next(t1, cmp1_out, live_pv,
				spa1_reg, spb1_reg, hyst_reg);
			cmp2_out <= cmp_next(t2, cmp2_out, live_pv,
				spa2_reg, spb2_reg, hyst_reg);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			color_red <= 1'b0;
		end else begin
			unique case (cmode)
				CM_G2R:   color_red <= cmp1_out | cmp2_out;
				CM_GREEN: color_red <= 1'b0;
				CM_RED:   color_red <= 1'b1;
				CM_R2G:   color_red <= ~(cmp1_out | cmp2_out);
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pv_out <= 32'h0000_0000;
			pv_upd <= 1'b0;
		end else begin
			pv_out <= hold_reg ? held_reg : live_pv;
			pv_upd <= upd_reg;
		end
	end

	AST_HOLD_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
		hold_reg && $past(hold_reg) && $past(hold_reg, 2) |->
		$stable(pv_out)) else $error("held value moved");
	AST_UPPER_ON: assert property (@(posedge clk_sys) disable iff (!arst_n)
		upd_reg && t1 == CT_UPPER && live_pv >= spa1_reg |=> cmp1_out)
		else $error("upper limit not asserted");
	AST_LOWER_OFF: assert property (@(posedge clk_sys)
		disable iff (!arst_n)
		upd_reg && t2 == CT_LOWER && live_pv > spa2_reg &&
		live_pv < spa2_reg + signed'({18'h0_0000, hyst_reg}) |=>
		cmp2_out == $past(cmp2_out))
		else $error("lower limit ignored hysteresis");
	AST_COLOR: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cmode == CM_G2R |=> color_red == ($past(cmp1_out) | $past(cmp2_out)))
		else $error("colour does not follow compares");
endmodule

// File: tb/pvp_contact_src.sv
// model of the external contact or transistor source on the shared input
// assumes the bench calls drive() from one process at a time
module pvp_contact_src #(
	parameter int MIN_HOLD = 12
) (
	input  wire logic clk_sys,
	output logic      ext_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// level driver
	// ****************************************************************
	initial begin
		ext_in = 1'b0;
	end
	// chatter of 2-cycle level and 3-cycle opposite spikes, then a settled level
	task automatic drive(input logic lvl, input int hold, input int bnc);
		repeat (bnc) begin
			@(posedge clk_sys) ext_in <= lvl;
			repeat (2) @(posedge clk_sys);
			ext_in <= ~lvl;
			repeat (2) @(posedge clk_sys);
		end
		@(posedge clk_sys) ext_in <= lvl;
		// settled level never shorter than the minimum width
		repeat ((hold < MIN_HOLD) ? MIN_HOLD : hold) @(posedge clk_sys);
	endtask
endmodule

// File: tb/pvp_top_tb.sv
// self-checking bench of the process value postprocessor
// assumes shortened filter and cancel counts set by parameters below
module pvp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pvp_pkg::*;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic        clk_sys;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] meas_data;
	logic        meas_strobe;
	logic        pulse_slow;
	logic        ext_in;
	logic        nv_zero_act;
	logic [31:0] nv_offset;
	logic        nv_wr;
	logic        nv_wr_zero_act;
	logic [31:0] nv_wr_offset;
	logic [31:0] pv_out;
	logic        pv_upd;
	logic        cmp1_out;
	logic        cmp2_out;
	logic        color_red;
	logic [31:0] rdata;
	logic        rerr;
	int          n_fail;
	int          samples_checked;
	int          n_upd;
	int          n_nvwr;
	int          u0;
	int          s;
	// ****************************************************************
	// design and source model
	// ****************************************************************
	pvp_top #(.EVT_FLT_CYC(20), .SLOW_FLT_CYC(10), .ZERO_CLR_CYC(50)) u_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .meas_data(meas_data),
		.meas_strobe(meas_strobe), .pulse_slow(pulse_slow), .ext_in(ext_in),
		.nv_zero_act(nv_zero_act), .nv_offset(nv_offset), .nv_wr(nv_wr),
		.nv_wr_zero_act(nv_wr_zero_act), .nv_wr_offset(nv_wr_offset),
		.pv_out(pv_out), .pv_upd(pv_upd), .cmp1_out(cmp1_out),
		.cmp2_out(cmp2_out), .color_red(color_red));
	pvp_contact_src #(.MIN_HOLD(12)) u_src (.clk_sys(clk_sys), .ext_in(ext_in));
	// ****************************************************************
	// clock, counters and tasks
	// ****************************************************************
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (pv_upd === 1'b1) n_upd++;
		if (nv_wr === 1'b1) n_nvwr++;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic meas(input int v);
		@(posedge clk_sys) meas_data <= 32'(v); meas_strobe <= 1'b1;
		@(posedge clk_sys) meas_strobe <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	function automatic logic [31:0] ctrl(int it, int av, int ef, int cl, int t1, int t2);
		return 32'(it | av << CTRL_AVG | ef << CTRL_EVTF | cl << CTRL_COLOR
			| t1 << CTRL_T1 | t2 << CTRL_T2);
	endfunction
	task automatic report_and_stop;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		report_and_stop;
	end
	// ****************************************************************
	// tests
	// ****************************************************************
	int tv [10] = '{100, 91, 90, 50, 59, 60, 100, 91, 75, 50};
	int t1 [10] = '{1, 1, 0, 0, 0, 0, 1, 1, 0, 1};
	int t2 [10] = '{0, 0, 0, 1, 1, 0, 0, 0, 0, 0};
	initial begin
		clk_sys = 1'b0; arst_n = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
		meas_data = 32'h0000_0000; meas_strobe = 1'b0; pulse_slow = 1'b0;
		nv_zero_act = 1'b0; nv_offset = 32'h0000_0000;
		n_fail = 0; samples_checked = 0; n_upd = 0; n_nvwr = 0;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		apb(0, OFS_CTRL, 0); chk("ctrl_rst", 0, rdata);
		apb(0, OFS_HYST, 0); chk("hyst_rst", 1, rdata);
		apb(0, 8'h24, 0); chk("unmapped_err", 1, 32'(rerr));
		apb(1, OFS_HYST, 0); apb(0, OFS_HYST, 0); chk("hyst_0", 1, rdata);
		apb(1, OFS_HYST, 10000); apb(0, OFS_HYST, 0); chk("hyst_big", 1, rdata);
		apb(1, OFS_HYST, 9999); apb(0, OFS_HYST, 0); chk("hyst_max", 9999, rdata);
		// averaging over 1, 2, 4, 8 samples
		for (int k = 0; k < 4; k++) begin
			apb(1, OFS_CTRL, ctrl(0, k, 0, 0, 0, 0));
			u0 = n_upd;
			s = 0;
			for (int i = 0; i < (1 << k); i++) begin
				if (i == (1 << k) - 1) chk("upd_early", 32'(u0), 32'(n_upd));
				meas(i * 5 - 9);
				s += i * 5 - 9;
			end
			chk("upd_once", 32'(u0 + 1), 32'(n_upd));
			chk("pv_mean", 32'(s >>> k), pv_out);
		end
		// compares: upper and lower, then range with idle upper
		apb(1, OFS_HYST, 10);
		apb(1, OFS_SPA1, 100); apb(1, OFS_SPA2, 50); apb(1, OFS_SPB1, 50);
		apb(1, OFS_CTRL, ctrl(0, 0, 0, 0, CT_UPPER, CT_LOWER));
		for (int i = 0; i < 10; i++) begin
			if (i == 6) begin
				apb(1, OFS_SPA2, 1000);
				apb(1, OFS_CTRL, ctrl(0, 0, 0, 0, CT_RANGE, CT_UPPER));
			end
			meas(tv[i]);
			chk("cmp1", 32'(t1[i]), 32'(cmp1_out));
			chk("cmp2", 32'(t2[i]), 32'(cmp2_out));
		end
		// colour modes with an output on, then with both off
		apb(1, OFS_CTRL, ctrl(0, 0, 0, 0, CT_UPPER, CT_UPPER));
		for (int a = 1; a >= 0; a--) begin
			meas(a * 100);
			for (int c = 0; c < 4; c++) begin
				apb(1, OFS_CTRL, ctrl(0, 0, 0, c, CT_UPPER, CT_UPPER));
				repeat (3) @(posedge clk_sys);
				chk("color_red", 32'(c == 2 || (c == 0 && a == 1) || (c == 3 && a == 0)),
					32'(color_red));
			end
		end
		// hold through the event input, after a rejected glitch
		apb(1, OFS_CTRL, ctrl(IT_ANALOG, 0, 0, 0, 0, 0));
		meas(40);
		u_src.drive(1'b0, 30, 2);
		meas(70); chk("pv_glitch", 70, pv_out);
		u_src.drive(1'b1, 30, 0);
		meas(90); chk("pv_held", 70, pv_out);
		u_src.drive(1'b0, 30, 0); chk("pv_live", 90, pv_out);
		// zero by key, then by event, then long press cancels
		apb(1, OFS_CTRL, ctrl(IT_REMOTE, 0, 1, 0, 0, 0));
		meas(40);
		u0 = n_nvwr;
		apb(1, OFS_KEY, 32'(1 << KEY_SET));
		repeat (3) @(posedge clk_sys);
		chk("nv_wr_key", 32'(u0 + 1), 32'(n_nvwr));
		chk("nv_offset", 40, nv_wr_offset);
		chk("pv_key_zero", 0, pv_out);
		meas(60); chk("pv_rel", 20, pv_out);
		u_src.drive(1'b1, 30, 0); chk("pv_evt_zero", 0, pv_out);
		chk("nv_wr_evt", 32'(u0 + 1), 32'(n_nvwr));
		u_src.drive(1'b0, 30, 0);
		meas(65); chk("pv_rel2", 5, pv_out);
		u_src.drive(1'b1, 80, 0); chk("pv_cancel", 65, pv_out);
		u_src.drive(1'b0, 30, 0);
		apb(1, OFS_KEY, 32'(1 << KEY_CLR));
		repeat (3) @(posedge clk_sys);
		chk("nv_wr_clr", 32'(u0 + 2), 32'(n_nvwr));
		chk("nv_zero_act", 0, 32'(nv_wr_zero_act));
		// slow pulses with chatter update once per n pulses, no zeroing
		apb(1, OFS_CTRL, ctrl(IT_PULSE, 0, 1, 0, 0, 0));
		meas_data <= 32'd33;
		pulse_slow <= 1'b1;
		u0 = n_nvwr;
		apb(1, OFS_KEY, 32'(1 << KEY_SET));
		repeat (3) @(posedge clk_sys);
		chk("nv_wr_pulse", 32'(u0), 32'(n_nvwr));
		for (int k = 0; k < 2; k++) begin
			apb(1, OFS_CTRL, ctrl(IT_PULSE, k, 1, 0, 0, 0));
			u0 = n_upd;
			for (int i = 0; i < (1 << k); i++) begin
				if (i == 1) chk("pulse_early", 32'(u0), 32'(n_upd));
				u_src.drive(1'b1, 15, 2);
				u_src.drive(1'b0, 15, 0);
			end
			chk("pulse_upd", 32'(u0 + 1), 32'(n_upd));
			chk("pv_pulse", 33, pv_out);
		end
		// fast pulses pass unfiltered, one update per pulse
		apb(1, OFS_CTRL, ctrl(IT_PULSE, 0, 1, 0, 0, 0) | 32'(1 << CTRL_FAST));
		meas_data <= 32'd44;
		u0 = n_upd;
		u_src.drive(1'b1, 2, 0);
		u_src.drive(1'b0, 2, 0);
		chk("pulse_fast", 32'(u0 + 1), 32'(n_upd));
		chk("pv_fast", 44, pv_out);
		// mid-run reset restores the stored zero offset
		nv_zero_act <= 1'b1;
		nv_offset <= 32'h0000_0007;
		arst_n <= 1'b0;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		apb(0, OFS_STAT, 0); chk("stat_nv", 32'h0000_0008, rdata);
		apb(0, OFS_PV, 0); chk("pv_nv", 32'hFFFF_FFF9, rdata);
		meas(10); chk("pv_nv_rel", 3, pv_out);
		report_and_stop;
	end
endmodule
